// ### design/can_and_reference_clock_gen_map.svh
`ifndef CAN_AND_REFERENCE_CLOCK_GEN_MAP_SVH
`define CAN_AND_REFERENCE_CLOCK_GEN_MAP_SVH

// word offsets on the bus
`define BUS_CLOCK_CONTROL_OFS 32'h0000_0000
`define REFCLK_CONTROL_LOW_OFS 32'h0000_0004
`define REFCLK_CONTROL_HIGH_OFS 32'h0000_0008

// bus_clock_control fields
`define BUS_CLKGEN_ENABLE_BIT 15
`define BUS_CLK_SOURCE_SELECT_MSB 11
`define BUS_CLK_SOURCE_SELECT_LSB 8
`define BUS_CLK_DIVIDER_MSB 6
`define BUS_CLK_DIVIDER_LSB 0

// refclk_control_low fields
`define REFGEN_ENABLE_BIT 15
`define REFGEN_IDLE_RUN_BIT 13
`define REFGEN_PIN_OUTPUT_ENABLE_BIT 12
`define REFGEN_SLEEP_RUN_BIT 11
`define REFGEN_DIVIDER_SWITCH_REQUEST_BIT 9
`define REFGEN_ACTIVE_STATUS_BIT 8
`define REFGEN_SOURCE_SELECT_MSB 3
`define REFGEN_SOURCE_SELECT_LSB 0

// refclk_control_high fields
`define REFGEN_DIVIDER_MSB 14
`define REFGEN_DIVIDER_LSB 0

// reset values
`define BUS_CLOCK_CONTROL_RST 16'h0000
`define REFCLK_CONTROL_LOW_RST 16'h0000
`define REFCLK_CONTROL_HIGH_RST 16'h0000

// source tap counts
`define BUS_TAP_COUNT 10
`define REF_TAP_COUNT 8

`endif

// ### design/clkgen_pkg.sv
package clkgen_pkg;

    typedef enum logic [1:0] {
        REF_STOPPED,
        REF_RUNNING,
        REF_STOPPING
    } ref_state_e;

    typedef logic [3:0] src_code_t;
    typedef logic [6:0] bus_div_t;
    typedef logic [14:0] ref_div_t;

endpackage

// ### design/can_and_reference_clock_gen.sv
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "can_and_reference_clock_gen_map.svh"

module can_and_reference_clock_gen (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // power modes, same clock domain
    input wire logic idle_mode_i,
    input wire logic sleep_mode_i,
    input wire logic aux_pll_enable_i,
    // bus clock source taps, asynchronous
    input wire logic main_vco_i,
    input wire logic main_pll_out_i,
    input wire logic main_vco_div2_i,
    input wire logic main_vco_div3_i,
    input wire logic main_vco_div4_i,
    input wire logic aux_pll_post_div_i,
    input wire logic aux_pll_bypass_i,
    input wire logic aux_vco_i,
    input wire logic aux_vco_div2_i,
    input wire logic aux_vco_div3_i,
    input wire logic aux_vco_div4_i,
    // reference clock sources, asynchronous
    input wire logic system_clock_i,
    input wire logic peripheral_clock_i,
    input wire logic primary_osc_i,
    input wire logic fast_rc_osc_i,
    input wire logic low_power_rc_osc_i,
    input wire logic backup_rc_osc_i,
    input wire logic reference_input_pin_i,
    // clock outputs
    output logic bus_clk_o,
    output logic ref_clk_o,
    output logic reference_output_pin_o,
    output logic reference_output_pin_oe_n_o
);
    import clkgen_pkg::*;

    localparam int RAW_W = 18;

    // pick a synchronized tap; out-of-range codes give no clock
    function automatic logic pick_bus(input logic [9:0] taps, input src_code_t code);
        logic r;
        r = 1'b0;
        if (code != 4'h0 && code <= 4'hA) begin
            r = taps[code - 4'h1];
        end
        return r;
    endfunction

    function automatic logic pick_ref(input logic [7:0] taps, input src_code_t code);
        logic r;
        r = 1'b0;
        if (code <= 4'h7) begin
            r = taps[code[2:0]];
        end
        return r;
    endfunction

    logic [RAW_W-1:0] raw;
    logic [RAW_W-1:0] sync1_q, sync2_q, sync3_q, lvl_q, lvl_d;
    logic [9:0] bus_lvl, bus_prev;
    logic [7:0] ref_lvl, ref_prev;

    // registers
    logic bus_en_q;
    src_code_t bus_sel_q;
    bus_div_t bus_div_q;
    logic ref_en_q, ref_idle_run_q, ref_pin_en_q, ref_sleep_run_q, ref_swreq_q;
    src_code_t ref_sel_q;
    ref_div_t ref_div_q;

    // active reference settings
    src_code_t ref_sel_act_q;
    ref_div_t ref_div_act_q;
    ref_state_e ref_state_q;
    ref_div_t ref_cnt_q;
    logic ref_q, ref_active_q;

    logic [6:0] bus_cnt_q, bus_cnt_d;
    logic [7:0] bus_half;
    logic bus_q;

    logic wr_hit, rd_hit, swreq_done, ref_run_ok;
    logic bus_src_lvl, bus_src_edge, ref_src_lvl, ref_src_edge;

    assign raw = {reference_input_pin_i, backup_rc_osc_i, low_power_rc_osc_i,
                  fast_rc_osc_i, primary_osc_i, peripheral_clock_i, system_clock_i,
                  aux_vco_div4_i, aux_vco_div3_i, aux_vco_div2_i, aux_vco_i,
                  aux_pll_post_div_i, aux_pll_bypass_i,
                  main_vco_div4_i, main_vco_div3_i, main_vco_div2_i,
                  main_pll_out_i, main_vco_i};

    // a level is accepted only once stages two and three agree
    always_comb begin
        for (int i = 0; i < RAW_W; i++) begin
            lvl_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : lvl_q[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            lvl_q <= '0;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            lvl_q <= lvl_d;
        end
    end

    // tap order: main vco, main pll, vco/2/3/4, aux pll, aux vco, aux vco/2/3/4
    always_comb begin
        bus_lvl[4:0] = lvl_d[4:0];
        bus_lvl[5] = aux_pll_enable_i ? lvl_d[6] : lvl_d[5];
        bus_lvl[9:6] = lvl_d[10:7];
        bus_prev[4:0] = lvl_q[4:0];
        bus_prev[5] = aux_pll_enable_i ? lvl_q[6] : lvl_q[5];
        bus_prev[9:6] = lvl_q[10:7];
        ref_lvl = {lvl_d[17], lvl_d[4], lvl_d[16:11]};
        ref_prev = {lvl_q[17], lvl_q[4], lvl_q[16:11]};
    end

    assign bus_src_lvl = pick_bus(bus_lvl, bus_sel_q);
    assign bus_src_edge = bus_src_lvl & ~pick_bus(bus_prev, bus_sel_q);
    assign ref_src_lvl = pick_ref(ref_lvl, ref_sel_act_q);
    assign ref_src_edge = ref_src_lvl & ~pick_ref(ref_prev, ref_sel_act_q);

    // wishbone: ack one cycle after the request, write lands at the acked edge
    assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign rd_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_hit) begin
            if (wb_adr_i == `BUS_CLOCK_CONTROL_OFS) begin
                wb_dat_o <= {16'h0000, bus_en_q, 3'h0, bus_sel_q, 1'b0, bus_div_q};
            end else if (wb_adr_i == `REFCLK_CONTROL_LOW_OFS) begin
                wb_dat_o <= {16'h0000, ref_en_q, 1'b0, ref_idle_run_q, ref_pin_en_q,
                             ref_sleep_run_q, 1'b0, ref_swreq_q, ref_active_q,
                             4'h0, ref_sel_q};
            end else if (wb_adr_i == `REFCLK_CONTROL_HIGH_OFS) begin
                wb_dat_o <= {17'h0_0000, ref_div_q};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {bus_en_q, bus_sel_q, bus_div_q} <= 12'h000;
        end else if (wr_hit && wb_adr_i == `BUS_CLOCK_CONTROL_OFS) begin
            if (wb_sel_i[1]) begin
                bus_en_q <= wb_dat_i[`BUS_CLKGEN_ENABLE_BIT];
                bus_sel_q <= wb_dat_i[`BUS_CLK_SOURCE_SELECT_MSB:`BUS_CLK_SOURCE_SELECT_LSB];
            end
            if (wb_sel_i[0]) begin
                bus_div_q <= wb_dat_i[`BUS_CLK_DIVIDER_MSB:`BUS_CLK_DIVIDER_LSB];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {ref_en_q, ref_idle_run_q, ref_pin_en_q, ref_sleep_run_q} <= 4'h0;
            ref_sel_q <= 4'h0;
        end else if (wr_hit && wb_adr_i == `REFCLK_CONTROL_LOW_OFS) begin
            if (wb_sel_i[1]) begin
                ref_en_q <= wb_dat_i[`REFGEN_ENABLE_BIT];
                ref_idle_run_q <= wb_dat_i[`REFGEN_IDLE_RUN_BIT];
                ref_pin_en_q <= wb_dat_i[`REFGEN_PIN_OUTPUT_ENABLE_BIT];
                ref_sleep_run_q <= wb_dat_i[`REFGEN_SLEEP_RUN_BIT];
            end
            if (wb_sel_i[0]) begin
                ref_sel_q <= wb_dat_i[`REFGEN_SOURCE_SELECT_MSB:`REFGEN_SOURCE_SELECT_LSB];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_div_q <= 15'h0000;
        end else if (wr_hit && wb_adr_i == `REFCLK_CONTROL_HIGH_OFS) begin
            if (wb_sel_i[1]) begin
                ref_div_q[14:8] <= wb_dat_i[14:8];
            end
            if (wb_sel_i[0]) begin
                ref_div_q[7:0] <= wb_dat_i[7:0];
            end
        end
    end

    // a software set in the completing cycle wins over the hardware clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_swreq_q <= 1'b0;
        end else if (wr_hit && wb_adr_i == `REFCLK_CONTROL_LOW_OFS && wb_sel_i[1]) begin
            ref_swreq_q <= wb_dat_i[`REFGEN_DIVIDER_SWITCH_REQUEST_BIT];
        end else if (swreq_done) begin
            ref_swreq_q <= 1'b0;
        end
    end

    // bus clock divider
    assign bus_half = ({1'b0, bus_div_q} + 8'h01) >> 1;

    always_comb begin
        bus_cnt_d = bus_cnt_q;
        if (bus_src_edge) begin
            bus_cnt_d = (bus_cnt_q >= bus_div_q) ? 7'h00 : bus_cnt_q + 7'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !bus_en_q || bus_sel_q == 4'h0 || bus_sel_q > 4'hA) begin
            bus_cnt_q <= 7'h00;
            bus_q <= 1'b0;
        end else begin
            bus_cnt_q <= bus_cnt_d;
            if (bus_div_q == 7'h00) begin
                bus_q <= bus_src_lvl;
            end else if (bus_src_edge) begin
                bus_q <= ({1'b0, bus_cnt_d} < bus_half);
            end
        end
    end

    // reference generator
    assign ref_run_ok = ref_en_q
                        & ~(idle_mode_i & ~ref_idle_run_q)
                        & ~(sleep_mode_i & ~ref_sleep_run_q);
    // changes only while the output is low, so no runt pulse escapes
    assign swreq_done = (ref_state_q == REF_RUNNING) && ref_swreq_q && !ref_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_state_q <= REF_STOPPED;
            ref_sel_act_q <= 4'h0;
            ref_div_act_q <= 15'h0000;
            ref_cnt_q <= 15'h0000;
            ref_q <= 1'b0;
        end else begin
            case (ref_state_q)
                REF_STOPPED: begin
                    ref_q <= 1'b0;
                    if (ref_run_ok) begin
                        ref_sel_act_q <= ref_sel_q;
                        ref_div_act_q <= ref_div_q;
                        ref_cnt_q <= 15'h0000;
                        ref_state_q <= REF_RUNNING;
                    end
                end
                REF_RUNNING, REF_STOPPING: begin
                    if (ref_state_q == REF_RUNNING && !ref_run_ok) begin
                        ref_state_q <= REF_STOPPING;
                    end
                    if (swreq_done) begin
                        ref_sel_act_q <= ref_sel_q;
                        ref_div_act_q <= ref_div_q;
                        ref_cnt_q <= 15'h0000;
                    end else if (ref_state_q == REF_STOPPING && !ref_q) begin
                        ref_state_q <= REF_STOPPED;
                    end else if (ref_div_act_q == 15'h0000) begin
                        // rises only on a source edge, so a mid-phase start cuts no pulse
                        ref_q <= ref_src_lvl & (ref_q | ref_src_edge);
                    end else if (ref_src_edge) begin
                        if (ref_cnt_q >= ref_div_act_q - 15'h0001) begin
                            ref_cnt_q <= 15'h0000;
                            ref_q <= ~ref_q;
                        end else begin
                            ref_cnt_q <= ref_cnt_q + 15'h0001;
                        end
                    end
                end
                default: begin
                    ref_state_q <= REF_STOPPED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_active_q <= 1'b0;
            bus_clk_o <= 1'b0;
            ref_clk_o <= 1'b0;
            reference_output_pin_o <= 1'b0;
            reference_output_pin_oe_n_o <= 1'b1;
        end else begin
            ref_active_q <= (ref_state_q != REF_STOPPED);
            bus_clk_o <= bus_q;
            ref_clk_o <= ref_q;
            reference_output_pin_o <= ref_q & ref_pin_en_q;
            reference_output_pin_oe_n_o <= ~(ref_pin_en_q & ref_en_q);
        end
    end

endmodule

// ### testbench/can_and_reference_clock_gen_checker.sv
`timescale 1ns/1ps
module can_and_reference_clock_gen_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // modes and clocks
    input wire logic idle_mode_i,
    input wire logic sleep_mode_i,
    input wire logic bus_clk_o,
    input wire logic ref_clk_o,
    input wire logic reference_output_pin_o,
    input wire logic reference_output_pin_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] bus_hi_q;
    logic [7:0] ref_hi_q;
    logic [6:0] bus_off_q;
    logic [6:0] ref_off_q;
    logic wr;
    logic bus_off;
    logic ref_stop;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[1];
    assign bus_off = !bus_hi_q[7] || bus_hi_q[3:0] == 4'h0 || bus_hi_q[3:0] > 4'hA;
    assign ref_stop = !ref_hi_q[7] || (idle_mode_i && !ref_hi_q[5])
        || (sleep_mode_i && !ref_hi_q[3]);
    // shadow of the upper byte lanes, taken at the acked edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_hi_q <= 8'h00;
            ref_hi_q <= 8'h00;
        end else if (wr && wb_adr_i == 32'h0000_0000) begin
            bus_hi_q <= wb_dat_i[15:8];
        end else if (wr && wb_adr_i == 32'h0000_0004) begin
            ref_hi_q <= wb_dat_i[15:8];
        end
    end
    // saturating age counters cover synchroniser lag and the wait for a low phase
    always_ff @(posedge clk_i) begin
        if (rst_i || !bus_off) begin
            bus_off_q <= 7'h00;
        end else if (bus_off_q != 7'h7F) begin
            bus_off_q <= bus_off_q + 7'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || !ref_stop) begin
            ref_off_q <= 7'h00;
        end else if (ref_off_q != 7'h7F) begin
            ref_off_q <= ref_off_q + 7'h01;
        end
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack_next;
        s_req |=> s_ack;
    endproperty
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    property p_dat_hi_zero;
        wb_dat_o[31:16] == 16'h0000;
    endproperty
    property p_bus_silent;
        bus_off_q == 7'h7F |-> !bus_clk_o;
    endproperty
    property p_ref_silent;
        ref_off_q == 7'h7F |-> !ref_clk_o;
    endproperty
    property p_pin_follows;
        reference_output_pin_o |-> (ref_clk_o || $past(ref_clk_o));
    endproperty
    property p_ref_no_runt_hi;
        $rose(ref_clk_o) |=> ref_clk_o [*2];
    endproperty
    property p_ref_no_runt_lo;
        $fell(ref_clk_o) |=> !ref_clk_o [*2];
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("ack not one cycle after request");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    a_dat_hi_zero: assert property (p_dat_hi_zero)
        else $error("upper read data not zero");
    a_bus_silent: assert property (p_bus_silent)
        else $error("bus clock toggles while off");
    a_ref_silent: assert property (p_ref_silent)
        else $error("reference clock runs while stopped");
    a_pin_follows: assert property (p_pin_follows)
        else $error("pin high without reference clock");
    a_ref_no_runt_hi: assert property (p_ref_no_runt_hi)
        else $error("short high pulse on reference clock");
    a_ref_no_runt_lo: assert property (p_ref_no_runt_lo)
        else $error("short low pulse on reference clock");
endmodule
bind can_and_reference_clock_gen can_and_reference_clock_gen_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .idle_mode_i(idle_mode_i),
    .sleep_mode_i(sleep_mode_i), .bus_clk_o(bus_clk_o), .ref_clk_o(ref_clk_o),
    .reference_output_pin_o(reference_output_pin_o),
    .reference_output_pin_oe_n_o(reference_output_pin_oe_n_o));

// ### testbench/can_and_reference_clock_gen_tb.sv
`timescale 1ns/1ps
`include "can_and_reference_clock_gen_map.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module can_and_reference_clock_gen_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0, slp = 1'b0, aux_en = 1'b1;
    logic [31:0] adr = 32'h0, dat = 32'h0, tick = 32'h0, rdat;
    logic [17:0] src = 18'h0;
    logic [3:0] lanes = 4'hF, sel = 4'hF;
    logic ack, bclk, rclk, pin, oe_n;
    int num_errors = 0, tests_run = 0;
    int bidx[11] = '{0, 0, 1, 2, 3, 4, 5, 7, 8, 9, 10};
    int ridx[8] = '{11, 12, 13, 14, 15, 16, 4, 17};
    int bdv[3] = '{1, 2, 127};
    can_and_reference_clock_gen DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .idle_mode_i(idle), .sleep_mode_i(slp), .aux_pll_enable_i(aux_en),
        .main_vco_i(src[0]), .main_pll_out_i(src[1]), .main_vco_div2_i(src[2]),
        .main_vco_div3_i(src[3]), .main_vco_div4_i(src[4]), .aux_pll_post_div_i(src[5]),
        .aux_pll_bypass_i(src[6]), .aux_vco_i(src[7]), .aux_vco_div2_i(src[8]),
        .aux_vco_div3_i(src[9]), .aux_vco_div4_i(src[10]), .system_clock_i(src[11]),
        .peripheral_clock_i(src[12]), .primary_osc_i(src[13]), .fast_rc_osc_i(src[14]),
        .low_power_rc_osc_i(src[15]), .backup_rc_osc_i(src[16]),
        .reference_input_pin_i(src[17]), .bus_clk_o(bclk), .ref_clk_o(rclk),
        .reference_output_pin_o(pin), .reference_output_pin_oe_n_o(oe_n));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // each source gets its own half period of 4+i cycles, so a period names its source
    always @(posedge clk_i) begin
        tick <= tick + 1;
        for (int i = 0; i < 18; i++) src[i] <= (tick % (8 + 2 * i)) < (4 + i);
    end
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [31:0] a, input logic [15:0] d,
                      output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= lanes;
        dat <= {16'h0000, d};
        do begin @(posedge clk_i); end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        logic [31:0] r;
        wb(1'b0, a, 16'h0000, r);
        `CHK("reg", {16'h0000, e}, r)
    endtask
    task automatic waitbit(input int b, input logic v);
        logic [31:0] r;
        int n;
        n = 0;
        do begin wb(1'b0, `REFCLK_CONTROL_LOW_OFS, 16'h0000, r); n++; end
            while (r[b] !== v && n < 200);
        `CHK("status bit", v, r[b])
    endtask
    // period between the 2nd and 3rd rising edge; 0 when the clock is still
    task automatic per(input int w, input int lim, input int e);
        int k, t, p;
        logic pv, c;
        k = 0;
        t = 0;
        p = 0;
        pv = 1'b1;
        for (int n = 0; n < lim && k < 3; n++) begin
            @(posedge clk_i);
            c = (w == 0) ? bclk : (w == 1) ? rclk : pin;
            if (c === 1'b1 && pv === 1'b0) begin
                if (k == 2) p = n - t;
                t = n;
                k++;
            end
            pv = c;
        end
        `CHK("period", e, p)
    endtask
    task automatic refgo(input logic [3:0] c, input logic [14:0] d, input logic [15:0] ctl);
        wr(`REFCLK_CONTROL_LOW_OFS, 16'h0000);
        waitbit(`REFGEN_ACTIVE_STATUS_BIT, 1'b0);
        wr(`REFCLK_CONTROL_HIGH_OFS, {1'b0, d});
        wr(`REFCLK_CONTROL_LOW_OFS, ctl | {12'h000, c});
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`BUS_CLOCK_CONTROL_OFS, 16'h0000);
        rd(`REFCLK_CONTROL_LOW_OFS, 16'h0000);
        rd(`REFCLK_CONTROL_HIGH_OFS, 16'h0000);
        rd(32'h0000_000C, 16'h0000);
        wr(`BUS_CLOCK_CONTROL_OFS, 16'hFFFF);
        rd(`BUS_CLOCK_CONTROL_OFS, 16'h8F7F);
        wr(`REFCLK_CONTROL_LOW_OFS, 16'h7CFF);
        rd(`REFCLK_CONTROL_LOW_OFS, 16'h380F);
        wr(`REFCLK_CONTROL_HIGH_OFS, 16'hFFFF);
        rd(`REFCLK_CONTROL_HIGH_OFS, 16'h7FFF);
        lanes = 4'h1;
        wr(`REFCLK_CONTROL_HIGH_OFS, 16'h0000);
        lanes = 4'hF;
        rd(`REFCLK_CONTROL_HIGH_OFS, 16'h7F00);
        for (int c = 0; c < 16; c++) begin
            wr(`BUS_CLOCK_CONTROL_OFS, {4'h8, c[3:0], 8'h00});
            per(0, 400, (c == 0 || c > 10) ? 0 : 2 * (4 + bidx[c]));
        end
        aux_en <= 1'b0;
        wr(`BUS_CLOCK_CONTROL_OFS, 16'h8600);
        per(0, 400, 20);
        aux_en <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(`BUS_CLOCK_CONTROL_OFS, 16'h0100);
            wr(`BUS_CLOCK_CONTROL_OFS, {8'h81, 1'b0, bdv[i][6:0]});
            per(0, 4000, (bdv[i] + 1) * 8);
        end
        wr(`BUS_CLOCK_CONTROL_OFS, 16'h0100);
        per(0, 400, 0);
        for (int c = 0; c < 16; c++) begin
            refgo(c[3:0], 15'h0000, 16'h8000);
            per(1, 400, (c > 7) ? 0 : 2 * (4 + ridx[c]));
        end
        for (int d = 1; d < 3; d++) begin
            refgo(4'h0, d[14:0], 16'h8000);
            per(1, 1000, 60 * d);
        end
        refgo(4'h0, 15'h0000, 16'h9000);
        waitbit(`REFGEN_ACTIVE_STATUS_BIT, 1'b1);
        `CHK("oe_n", 1'b0, oe_n)
        per(2, 400, 30);
        refgo(4'h0, 15'h0000, 16'h8000);
        waitbit(`REFGEN_ACTIVE_STATUS_BIT, 1'b1);
        `CHK("oe_n", 1'b1, oe_n)
        per(2, 400, 0);
        // switch on the fly, no stop in between
        wr(`REFCLK_CONTROL_HIGH_OFS, 16'h0001);
        wr(`REFCLK_CONTROL_LOW_OFS, 16'h8200);
        waitbit(`REFGEN_DIVIDER_SWITCH_REQUEST_BIT, 1'b0);
        per(1, 1000, 60);
        for (int m = 0; m < 2; m++) begin
            refgo(4'h0, 15'h0000, (m == 1) ? 16'h8800 : 16'hA000);
            idle <= (m == 0);
            slp <= (m == 1);
            per(1, 400, 30);
            refgo(4'h0, 15'h0000, 16'h8000);
            per(1, 400, 0);
            idle <= 1'b0;
            slp <= 1'b0;
            waitbit(`REFGEN_ACTIVE_STATUS_BIT, 1'b1);
        end
        close_out();
    end
endmodule
